/* core/psh_params.svh */
// psh_params.svh: timing counts and program-number limits for the program select / save handshake.
// Assumes a 50 MHz system clock and a millisecond timebase derived from it.
`ifndef PSH_PARAMS_SVH
`define PSH_PARAMS_SVH
`define PSH_CLK_HZ 50000000
`define PSH_CYC_PER_MS (`PSH_CLK_HZ / 1000)
`define PSH_PROG_MIN 4'h1
`define PSH_PROG_MAX 4'hF
`define PSH_PROG_NONE 4'h0
`define PSH_SAVE_DROP_MS 150
`define PSH_CHANGE_MIN_MS 150
`define PSH_SEL_SETUP_MS 100
`define PSH_TEACH_WAIT_MS 200
`define PSH_TRIG_HOLD_MS 5
`define PSH_SEL_BIT_SAVE 1
`endif

/* core/psh_pkg.sv */
// psh_pkg: types shared by both ends of the discrete handshake.
// Assumes psh_params.svh supplies the numeric constants.
package psh_pkg;
  typedef logic [3:0] psh_prog_t;
  typedef struct packed {
    logic decoded;
    logic matched;
    logic unreadable;
  } psh_result_s;
endpackage

/* core/psh_if.sv */
// psh_if: discrete wires between the reader and its controller.
// Assumes both ends share clk; all wires are plain levels.
`timescale 1ns/1ps
interface psh_if;
  logic local_lockout;
  logic [3:0] prog_sel;
  logic teach_request;
  logic acquire_strobe;
  logic error_clear;
  logic program_saved_flag;
  logic run_ready;
  logic result_decoded;
  logic result_match;
  logic result_unreadable;
  logic reader_error;
  modport reader (
    input local_lockout, prog_sel, teach_request, acquire_strobe, error_clear,
    output program_saved_flag, run_ready, result_decoded, result_match, result_unreadable, reader_error
  );
  modport controller (
    output local_lockout, prog_sel, teach_request, acquire_strobe, error_clear,
    input program_saved_flag, run_ready, result_decoded, result_match, result_unreadable, reader_error
  );
endinterface

/* core/psh_reader.sv */
// psh_reader: reader end; program select, save sequence, triggered processing, result flags.
// Assumes the image engine is external: change_done, proc_done and result arrive on the user side.
// How it works
// - select inputs form program 1..15
// - zero selection keeps current program
// - controller holds lockout high, others low
// - bit0 is program number LSB
// - program change drops saved and ready
// - change completion raises saved and ready
// - unsaved program keeps both flags low
// - controller holds target number 100 ms
// - teach raise drops saved and ready
// - controller waits 200 ms then saves
// - controller holds trigger at least 5 ms
// - saved flag acknowledges, controller drops bit1
// - teach fall: saved low 150 ms
// - processing resumes right after save ends
// - results: decoded, match, unreadable
// - error recovery: clear inputs, pulse clear
// - select and teach need lockout high
// - bit1 is save command during teach
// - trigger rising edge starts processing
// - ready low in startup/stop, high in run
`timescale 1ns/1ps
`include "psh_params.svh"
module psh_reader
  import psh_pkg::*;
#(
  parameter int CYC_PER_MS = `PSH_CYC_PER_MS,
  parameter int SAVE_DROP_MS = `PSH_SAVE_DROP_MS,
  parameter int SETTLE_MS = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  psh_if.reader link,
  input wire logic [15:0] prog_stored,
  input wire logic change_done,
  input wire logic save_done,
  input wire logic proc_done,
  input wire psh_result_s proc_result,
  input wire logic fault_event,
  output logic [3:0] active_prog,
  output logic change_start,
  output logic save_start,
  output logic acquire_start
);
  typedef enum logic [2:0] {
    PSH_RUN = 3'b000,
    PSH_CHANGE = 3'b001,
    PSH_TEACH = 3'b011,
    PSH_SAVED = 3'b010,
    PSH_DROP = 3'b110,
    PSH_STOP = 3'b111,
    PSH_START = 3'b101
  } psh_state_e;

  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= {link.local_lockout, link.prog_sel, link.teach_request, link.acquire_strobe, link.error_clear};
      sync2_reg <= sync1_reg;
    end
  end
  logic lock_s, teach_s, trig_s, clr_s;
  logic [3:0] sel_s;
  assign lock_s = sync2_reg[7];
  assign sel_s = sync2_reg[6:3];
  assign teach_s = sync2_reg[2];
  assign trig_s = sync2_reg[1];
  assign clr_s = sync2_reg[0];

  logic [31:0] div_reg;
  logic ms_tick;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 32'h0000_0000;
    end else if (div_reg == 32'(CYC_PER_MS - 1)) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end
  assign ms_tick = (div_reg == 32'(CYC_PER_MS - 1));

  // gate select and teach with lockout
  logic teach_g;
  logic [3:0] sel_g;
  assign teach_g = lock_s & teach_s;
  assign sel_g = lock_s ? sel_s : 4'h0;
  // bit1 is the save command while teaching
  logic save_cmd;
  assign save_cmd = teach_g & sel_g[`PSH_SEL_BIT_SAVE];
  // number with bit0 as LSB, valid 1..15
  logic [3:0] sel_num;
  assign sel_num = teach_g ? 4'h0 : sel_g;

  // selection must stay stable a few ms so a skewed bit pattern is not taken
  logic [3:0] last_sel_reg;
  logic [15:0] stable_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_sel_reg <= 4'h0;
      stable_reg <= 16'h0000;
    end else if (sel_num != last_sel_reg) begin
      last_sel_reg <= sel_num;
      stable_reg <= 16'h0000;
    end else if (ms_tick && stable_reg != 16'hFFFF) begin
      stable_reg <= stable_reg + 16'h0001;
    end
  end

  logic trig_d_reg, teach_d_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_d_reg <= 1'b0;
      teach_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_s;
      teach_d_reg <= teach_g;
    end
  end
  logic trig_rise, teach_fall, teach_rise;
  assign trig_rise = trig_s & ~trig_d_reg;
  assign teach_rise = teach_g & ~teach_d_reg;
  assign teach_fall = ~teach_g & teach_d_reg;

  psh_state_e state_reg;
  logic [3:0] prog_reg;
  logic [15:0] ms_reg;
  logic error_reg;
  logic sel_ok;
  // zero or unchanged selection never starts a change
  assign sel_ok = (sel_num >= `PSH_PROG_MIN) && (sel_num != prog_reg) && (stable_reg == 16'(SETTLE_MS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PSH_START;
      prog_reg <= `PSH_PROG_NONE;
      ms_reg <= 16'h0000;
    end else begin
      if (ms_tick) begin
        ms_reg <= ms_reg + 16'h0001;
      end
      unique case (state_reg)
        PSH_START: begin
          state_reg <= PSH_STOP;
        end
        PSH_STOP, PSH_RUN: begin
          if (teach_rise && !error_reg) begin
            state_reg <= PSH_TEACH;
          end else if (sel_ok && !error_reg) begin
            prog_reg <= sel_num;
            state_reg <= PSH_CHANGE;
          end
        end
        PSH_CHANGE: begin
          // run only when the program exists
          if (change_done) begin
            state_reg <= prog_stored[prog_reg] ? PSH_RUN : PSH_STOP;
          end
        end
        PSH_TEACH: begin
          if (teach_fall) begin
            state_reg <= PSH_STOP;
          end else if (save_done) begin
            state_reg <= PSH_SAVED;
          end
        end
        PSH_SAVED: begin
          // teach fall starts the drop window
          if (teach_fall) begin
            ms_reg <= 16'h0000;
            state_reg <= PSH_DROP;
          end
        end
        PSH_DROP: begin
          if (ms_reg >= 16'(SAVE_DROP_MS)) begin
            state_reg <= PSH_RUN;
          end
        end
        default: begin
          state_reg <= PSH_STOP;
        end
      endcase
    end
  end

  // error is sticky; set wins over the clear pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      error_reg <= 1'b0;
    end else if (fault_event) begin
      error_reg <= 1'b1;
    end else if (clr_s && lock_s && !teach_g && sel_g == 4'h0) begin
      error_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.program_saved_flag <= 1'b0;
      link.run_ready <= 1'b0;
      link.reader_error <= 1'b0;
      active_prog <= 4'h0;
      change_start <= 1'b0;
      save_start <= 1'b0;
      acquire_start <= 1'b0;
    end else begin
      link.run_ready <= (state_reg == PSH_RUN) && !error_reg;
      link.program_saved_flag <= (state_reg == PSH_SAVED) ||
        ((state_reg == PSH_RUN || state_reg == PSH_STOP) && prog_reg != 4'h0 && prog_stored[prog_reg]);
      link.reader_error <= error_reg;
      active_prog <= prog_reg;
      change_start <= (state_reg == PSH_STOP || state_reg == PSH_RUN) && sel_ok && !teach_rise && !error_reg;
      save_start <= (state_reg == PSH_TEACH) && save_cmd && trig_rise;
      // acquisition on trigger edge in run
      acquire_start <= (state_reg == PSH_RUN) && trig_rise && !error_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.result_decoded <= 1'b0;
      link.result_match <= 1'b0;
      link.result_unreadable <= 1'b0;
    end else if (proc_done) begin
      link.result_decoded <= proc_result.decoded;
      link.result_match <= proc_result.matched;
      link.result_unreadable <= proc_result.unreadable;
    end
  end
endmodule // psh_reader

/* core/psh_controller.sv */
// psh_controller: controller end; drives lockout, select, teach, trigger and error clear.
// Assumes user commands are one-cycle pulses; reader outputs arrive from another device.
`timescale 1ns/1ps
`include "psh_params.svh"
module psh_controller
  import psh_pkg::*;
#(
  parameter int CYC_PER_MS = `PSH_CYC_PER_MS,
  parameter int SETUP_MS = `PSH_SEL_SETUP_MS,
  parameter int WAIT_MS = `PSH_TEACH_WAIT_MS,
  parameter int TRIG_MS = `PSH_TRIG_HOLD_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  psh_if.controller link,
  input wire logic cmd_select,
  input wire logic cmd_save,
  input wire logic cmd_trigger,
  input wire logic cmd_clear,
  input wire logic [3:0] cmd_prog,
  output logic busy,
  output logic ready_seen,
  output logic saved_seen,
  output psh_result_s result_seen
);
  typedef enum logic [2:0] {
    PC_IDLE = 3'b000,
    PC_SETUP = 3'b001,
    PC_TEACH = 3'b011,
    PC_TRIG = 3'b010,
    PC_ACK = 3'b110,
    PC_PULSE = 3'b111,
    PC_CLR = 3'b101
  } pc_state_e;

  logic [5:0] s1_reg, s2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
    end else begin
      s1_reg <= {link.program_saved_flag, link.run_ready, link.result_decoded, link.result_match,
        link.result_unreadable, link.reader_error};
      s2_reg <= s1_reg;
    end
  end

  logic [31:0] div_reg;
  logic ms_tick;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 32'h0000_0000;
    end else if (ms_tick) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end
  assign ms_tick = (div_reg == 32'(CYC_PER_MS - 1));

  pc_state_e state_reg;
  logic [15:0] ms_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PC_IDLE;
      ms_reg <= 16'h0000;
      link.local_lockout <= 1'b0;
      link.prog_sel <= 4'h0;
      link.teach_request <= 1'b0;
      link.acquire_strobe <= 1'b0;
      link.error_clear <= 1'b0;
    end else begin
      link.local_lockout <= 1'b1;
      if (ms_tick) begin
        ms_reg <= ms_reg + 16'h0001;
      end
      unique case (state_reg)
        PC_IDLE: begin
          link.acquire_strobe <= 1'b0;
          ms_reg <= 16'h0000;
          if (cmd_clear) begin
            link.prog_sel <= 4'h0;
            link.teach_request <= 1'b0;
            state_reg <= PC_CLR;
          end else if (cmd_save) begin
            link.prog_sel <= cmd_prog;
            state_reg <= PC_SETUP;
          end else if (cmd_select) begin
            link.prog_sel <= cmd_prog;
          end else if (cmd_trigger) begin
            link.acquire_strobe <= 1'b1;
            state_reg <= PC_PULSE;
          end
        end
        PC_SETUP: begin
          if (ms_reg > 16'(SETUP_MS)) begin
            link.teach_request <= 1'b1;
            link.prog_sel <= 4'h0;
            ms_reg <= 16'h0000;
            state_reg <= PC_TEACH;
          end
        end
        PC_TEACH: begin
          if (ms_reg > 16'(WAIT_MS)) begin
            link.prog_sel <= 4'h2;
            link.acquire_strobe <= 1'b1;
            ms_reg <= 16'h0000;
            state_reg <= PC_TRIG;
          end
        end
        PC_TRIG: begin
          // trigger held at least 5 ms
          if (ms_reg > 16'(TRIG_MS)) begin
            link.acquire_strobe <= 1'b0;
            state_reg <= PC_ACK;
          end
        end
        PC_ACK: begin
          // drop bit1 and teach after ack
          if (s2_reg[5]) begin
            link.prog_sel <= 4'h0;
            link.teach_request <= 1'b0;
            state_reg <= PC_IDLE;
          end
        end
        PC_PULSE: begin
          if (ms_reg > 16'(TRIG_MS)) begin
            link.acquire_strobe <= 1'b0;
            state_reg <= PC_IDLE;
          end
        end
        PC_CLR: begin
          link.error_clear <= ~link.error_clear;
          if (link.error_clear) begin
            state_reg <= PC_IDLE;
          end
        end
        default: begin
          state_reg <= PC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      ready_seen <= 1'b0;
      saved_seen <= 1'b0;
      result_seen <= '0;
    end else begin
      busy <= (state_reg != PC_IDLE);
      saved_seen <= s2_reg[5];
      ready_seen <= s2_reg[4];
      result_seen <= {s2_reg[3], s2_reg[2], s2_reg[1]};
    end
  end
endmodule // psh_controller

/* verif/psh_link_chk.sv */
// psh_link_chk: timing checks on the wires between controller and reader.
// Assumes one clock domain; helper counters measure hold times in cycles.
`timescale 1ns/1ps
module psh_link_chk #(
  parameter int CYC_PER_MS = 10,
  parameter int SAVE_DROP_MS = 150
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic local_lockout,
  input wire logic [3:0] prog_sel,
  input wire logic teach_request,
  input wire logic acquire_strobe,
  input wire logic error_clear,
  input wire logic program_saved_flag,
  input wire logic run_ready,
  input wire logic reader_error
);
  localparam int SETUP_CYC = 100 * CYC_PER_MS - 1;
  localparam int WAIT_CYC = 200 * CYC_PER_MS - 1;
  localparam int TRIG_CYC = 5 * CYC_PER_MS;
  // one tick of slack: the drop is timed on the ms timebase, not the clock
  localparam int DROP_LO = (SAVE_DROP_MS - 1) * CYC_PER_MS;
  localparam int DROP_HI = (SAVE_DROP_MS + 1) * CYC_PER_MS;
  int sel_cnt;
  int teach_cnt;
  int trig_cnt;
  int low_cnt;
  logic exit_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_cnt <= 0;
      teach_cnt <= 0;
      trig_cnt <= 0;
      low_cnt <= 0;
    end else begin
      sel_cnt <= ($stable(prog_sel) && prog_sel != 4'h0) ? sel_cnt + 1 : 0;
      teach_cnt <= teach_request ? teach_cnt + 1 : 0;
      trig_cnt <= acquire_strobe ? trig_cnt + 1 : 0;
      low_cnt <= program_saved_flag ? 0 : low_cnt + 1;
    end
  end
  // marks the saved-flag gap that follows teach release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) exit_reg <= 1'b0;
    else if ($fell(teach_request)) exit_reg <= 1'b1;
    else if ($rose(program_saved_flag)) exit_reg <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_lock; (teach_request || error_clear || prog_sel != 4'h0) |-> local_lockout; endproperty
  a_lock: assert property (p_lock) else $error("select or teach without lockout");
  property p_setup; $rose(teach_request) |-> sel_cnt >= SETUP_CYC && prog_sel == 4'h0; endproperty
  a_setup: assert property (p_setup) else $error("teach raised too early");
  property p_teach_drop; $rose(teach_request) |-> ##[1:8] (!program_saved_flag && !run_ready); endproperty
  a_teach_drop: assert property (p_teach_drop) else $error("flags not dropped on teach");
  property p_wait; $rose(acquire_strobe) && teach_request |-> teach_cnt >= WAIT_CYC && prog_sel == 4'h2; endproperty
  a_wait: assert property (p_wait) else $error("save trigger too early");
  property p_hold; $fell(acquire_strobe) && teach_request |-> trig_cnt >= TRIG_CYC; endproperty
  a_hold: assert property (p_hold) else $error("save trigger too short");
  property p_ack; $rose(program_saved_flag) && teach_request |-> ##[1:8] !prog_sel[1]; endproperty
  a_ack: assert property (p_ack) else $error("save bit kept after ack");
  property p_drop; $rose(program_saved_flag) && exit_reg |-> low_cnt >= DROP_LO && low_cnt <= DROP_HI; endproperty
  a_drop: assert property (p_drop) else $error("saved gap length wrong");
  property p_run; $rose(program_saved_flag) && exit_reg |-> ##[0:4] run_ready; endproperty
  a_run: assert property (p_run) else $error("no run after save");
  property p_clear; error_clear |-> prog_sel == 4'h0 && !teach_request; endproperty
  a_clear: assert property (p_clear) else $error("clear with select or teach");
  c_teach: cover property ($rose(teach_request));
  c_exit: cover property ($rose(program_saved_flag) && exit_reg);
  c_clear: cover property ($fell(reader_error));
endmodule // psh_link_chk

/* verif/tb_program_select_save_handshake.sv */
// tb_program_select_save_handshake: controller and reader back to back, engine stand-in here.
// Assumes a shortened ms timebase; all stimulus and sampling at the falling edge.
`timescale 1ns/1ps
module tb_program_select_save_handshake
  import psh_pkg::*;
;
  localparam int C = 10;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] prog_stored = 16'h0800;
  logic change_done = 1'b0;
  logic save_done = 1'b0;
  logic proc_done = 1'b0;
  psh_result_s res = '0;
  logic fault_event = 1'b0;
  logic cmd_select = 1'b0;
  logic cmd_save = 1'b0;
  logic cmd_trigger = 1'b0;
  logic cmd_clear = 1'b0;
  logic [3:0] cmd_prog = 4'h0;
  logic [3:0] active_prog;
  logic change_start;
  logic save_start;
  logic acquire_start;
  logic busy;
  logic ready_seen;
  logic saved_seen;
  psh_result_s result_seen;
  int mismatches = 0;
  int cmp_count = 0;
  psh_if lnk();
  always #10 clk = ~clk;
  psh_reader #(.CYC_PER_MS(C)) psh_reader_inst (.clk(clk), .rst_b(rst_b), .link(lnk),
    .prog_stored(prog_stored), .change_done(change_done), .save_done(save_done), .proc_done(proc_done),
    .proc_result(res), .fault_event(fault_event), .active_prog(active_prog), .change_start(change_start),
    .save_start(save_start), .acquire_start(acquire_start));
  psh_controller #(.CYC_PER_MS(C)) psh_controller_inst (.clk(clk), .rst_b(rst_b), .link(lnk),
    .cmd_select(cmd_select), .cmd_save(cmd_save), .cmd_trigger(cmd_trigger), .cmd_clear(cmd_clear),
    .cmd_prog(cmd_prog), .busy(busy), .ready_seen(ready_seen), .saved_seen(saved_seen),
    .result_seen(result_seen));
  psh_link_chk #(.CYC_PER_MS(C)) psh_link_chk_inst (.clk(clk), .rst_b(rst_b),
    .local_lockout(lnk.local_lockout), .prog_sel(lnk.prog_sel), .teach_request(lnk.teach_request),
    .acquire_strobe(lnk.acquire_strobe), .error_clear(lnk.error_clear),
    .program_saved_flag(lnk.program_saved_flag), .run_ready(lnk.run_ready), .reader_error(lnk.reader_error));
  // engine stand-in answers each start after a fixed delay
  always @(posedge change_start) begin
    repeat (20) @(negedge clk);
    change_done = 1'b1;
    @(negedge clk);
    change_done = 1'b0;
  end
  // saving outlasts the 5 ms trigger hold, so the save bit is dropped just after the ack
  always @(posedge save_start) begin
    repeat (80) @(negedge clk);
    save_done = 1'b1;
    prog_stored[active_prog] = 1'b1;
    @(negedge clk);
    save_done = 1'b0;
  end
  always @(posedge acquire_start) begin
    repeat (5) @(negedge clk);
    proc_done = 1'b1;
    @(negedge clk);
    proc_done = 1'b0;
  end
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("ERROR t=%0t wait=%h limit=%h", $time, n, lim);
      conclude();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // k is one-hot {select, save, trigger, clear}; waits for an idle controller first
  task automatic pulse_cmd(input logic [3:0] p, input logic [3:0] k);
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) cyc(1);
    tmo(n, 3000);
    cmd_prog = p;
    {cmd_select, cmd_save, cmd_trigger, cmd_clear} = k;
    cyc(1);
    {cmd_select, cmd_save, cmd_trigger, cmd_clear} = 4'h0;
  endtask
  task automatic t_select(input logic [3:0] p, input logic st);
    int n;
    pulse_cmd(p, 4'h8);
    for (n = 0; n < 300 && change_start !== 1'b1; n++) cyc(1);
    tmo(n, 300);
    cyc(3);
    chk({lnk.program_saved_flag, lnk.run_ready}, 2'b00);
    cyc(25);
    chk({lnk.program_saved_flag, lnk.run_ready}, {st, st});
    if (st) chk(active_prog, p);
  endtask
  task automatic t_zero();
    int n;
    n = 0;
    pulse_cmd(4'h0, 4'h8);
    repeat (100) begin
      cyc(1);
      if (change_start === 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    chk(active_prog, 4'hB);
  endtask
  task automatic t_save();
    int n;
    // target is a stored program, so run and saved are high before teach and the drop is visible
    pulse_cmd(4'hB, 4'h4);
    for (n = 0; n < 1500 && lnk.teach_request !== 1'b1; n++) cyc(1);
    tmo(n, 1500);
    chk(16'(n >= 100 * C - 2), 16'h0001);
    chk(lnk.prog_sel, 4'h0);
    cyc(8);
    chk({lnk.program_saved_flag, lnk.run_ready}, 2'b00);
    for (n = 8; n < 3000 && save_start !== 1'b1; n++) cyc(1);
    tmo(n, 3000);
    chk(16'(n >= 200 * C), 16'h0001);
    chk({lnk.prog_sel, lnk.acquire_strobe}, 5'h05);
    for (n = 0; n < 300 && lnk.program_saved_flag !== 1'b1; n++) cyc(1);
    tmo(n, 300);
    for (n = 0; n < 300 && lnk.teach_request !== 1'b0; n++) cyc(1);
    tmo(n, 300);
    chk(lnk.prog_sel, 4'h0);
    for (n = 0; n < 20 && lnk.program_saved_flag !== 1'b0; n++) cyc(1);
    tmo(n, 20);
    for (n = 0; n < 2000 && lnk.program_saved_flag !== 1'b1; n++) cyc(1);
    tmo(n, 2000);
    chk(16'(n >= 149 * C && n <= 151 * C), 16'h0001);
    cyc(4);
    chk({lnk.run_ready, ready_seen, saved_seen}, 3'h7);
    chk(active_prog, 4'hB);
  endtask
  task automatic t_proc(input psh_result_s r);
    int n;
    res = r;
    pulse_cmd(4'h5, 4'h2);
    for (n = 0; n < 100 && acquire_start !== 1'b1; n++) cyc(1);
    tmo(n, 100);
    cyc(15);
    chk({lnk.result_decoded, lnk.result_match, lnk.result_unreadable}, r);
    chk(result_seen, r);
  endtask
  task automatic t_error();
    int n;
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(3);
    chk(lnk.reader_error, 1'b1);
    pulse_cmd(4'h0, 4'h1);
    for (n = 0; n < 50 && lnk.reader_error !== 1'b0; n++) cyc(1);
    tmo(n, 50);
  endtask
  initial begin
    cyc(12);
    rst_b = 1'b1;
    cyc(2);
    chk({lnk.program_saved_flag, lnk.run_ready}, 2'b00);
    t_select(4'h5, 1'b0);
    t_select(4'hB, 1'b1);
    t_zero();
    t_select(4'hC, 1'b0);
    t_save();
    t_proc(3'h4);
    t_proc(3'h6);
    t_proc(3'h1);
    t_error();
    conclude();
  end
endmodule // tb_program_select_save_handshake
